//--- pkg/ats_pkg.sv
package ats_pkg;
   // Clock select field codes and their CPU clock divisors
   localparam logic [1:0] CLK_SEL_DIV4 = 2'h0;
   localparam logic [1:0] CLK_SEL_DIV2 = 2'h1;
   localparam logic [1:0] CLK_SEL_DIV16 = 2'h2;
   localparam logic [1:0] CLK_SEL_DIV8 = 2'h3;
   localparam logic [4:0] DIV_BY_4 = 5'h04;
   localparam logic [4:0] DIV_BY_2 = 5'h02;
   localparam logic [4:0] DIV_BY_16 = 5'h10;
   localparam logic [4:0] DIV_BY_8 = 5'h08;
   // Sample time in basic clock periods per field code
   localparam logic [6:0] SAMPLE_BC_0 = 7'h08;
   localparam logic [6:0] SAMPLE_BC_1 = 7'h10;
   localparam logic [6:0] SAMPLE_BC_2 = 7'h20;
   localparam logic [6:0] SAMPLE_BC_3 = 7'h40;
   // Conversion step periods and trailing CPU cycles
   localparam logic [6:0] CONV_STEP_BC = 7'h28;
   localparam logic [1:0] LOAD_CPU_CYCLES = 2'h2;
   // Calibration length after reset, basic clock periods
   localparam int CAL_BC = 3328;
   // Result width and saturation values
   localparam int RES_W = 10;
   localparam logic [9:0] RES_ZERO = 10'h000;
   localparam logic [9:0] RES_FULL = 10'h3FF;

   // Converter control word as software programs it
   typedef struct packed {
      logic [1:0] conv_clock_select;  // Basic clock divisor code
      logic [1:0] sample_time_select; // Sample time code
   } ats_ctrl_s;

   // Analog front end report for one comparison input
   typedef struct packed {
      logic below_gnd;        // Input under reference ground
      logic above_ref;        // Input over reference supply
      logic [9:0] code;       // In-range quantised input
   } ats_ain_s;

   // Sequencer states, Gray from calibration through load
   typedef enum logic [2:0] {
      ST_CAL = 3'b000,
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b011,
      ST_CONV = 3'b010,
      ST_LOAD = 3'b110
   } ats_state_e;
endpackage : ats_pkg

//--- hw/ats_bc_divider.sv
`timescale 1ns/1ps
module ats_bc_divider
   import ats_pkg::*;
(
   input wire logic SYS_CLK, // CPU clock
   input wire logic RESET_N, // Async reset, active low
   input wire logic restart, // Realign divider to phase zero
   input wire logic [1:0] sel, // Clock select code
   output logic tick // One CPU cycle per basic clock period
);
   logic [4:0] cnt_r; // Divider count
   logic [4:0] div; // Selected divisor
   logic [4:0] cnt_nxt; // Next count
   logic wrap; // Last CPU cycle of basic period

   // Divisor decode
   assign div = (sel == CLK_SEL_DIV4) ? DIV_BY_4 :
                (sel == CLK_SEL_DIV2) ? DIV_BY_2 :
                (sel == CLK_SEL_DIV16) ? DIV_BY_16 : DIV_BY_8;
   assign wrap = (cnt_r >= div - 5'h01);
   assign cnt_nxt = (restart || wrap) ? 5'h00 : cnt_r + 5'h01;
   assign tick = wrap && !restart;

   // Counter on the CPU clock
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cnt_r <= 5'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule : ats_bc_divider

//--- hw/ats_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - Basic clock is CPU clock divided by select
// - Sample lasts 8, 16, 32 or 64 periods
// - Conversion lasts sample+40 periods+2 CPU cycles
// - Calibration after reset, 3328 basic periods
// - Out-of-range inputs saturate to 000 or 3FF
// - Input held once sample period ends
module ats_sequencer
   import ats_pkg::*;
#(
   parameter int CAL_PERIODS = CAL_BC // Calibration length in basic periods
)(
   input wire logic SYS_CLK, // CPU clock, 100 MHz
   input wire logic RESET_N, // Async reset, active low
   input wire ats_ctrl_s CTRL, // Clock and sample select fields
   input wire logic START, // Conversion request pulse
   input wire ats_ain_s AIN, // Analog front end report
   output logic BUSY, // Calibrating or converting
   output logic CAL_DONE, // Calibration finished
   output logic SAMPLING, // Sample switch closed
   output logic HOLD, // Sample captured, input ignored
   output logic DONE, // Result loaded pulse
   output logic [RES_W-1:0] RESULT // Conversion result
);
   ats_state_e state_r; // Sequencer state
   ats_state_e state_nxt; // Next state
   ats_ctrl_s ctrl_r; // Settings latched at start
   logic [11:0] per_cnt_r; // Basic period counter
   logic [11:0] per_cnt_nxt; // Next period count
   logic [1:0] load_cnt_r; // CPU cycles in load phase
   ats_ain_s held_r; // Held sample
   logic [RES_W-1:0] result_r; // Result register
   logic done_r; // Result loaded flag
   logic cal_done_r; // Calibration done flag
   logic tick; // Basic clock tick
   logic restart; // Divider realign
   logic [6:0] sample_len; // Sample periods for setting
   logic [11:0] phase_end; // Periods in current phase
   logic phase_last; // Final tick of the phase
   logic [RES_W-1:0] sat_code; // Saturated held value
   logic take_start; // Start accepted
   // Phase decode wires
   logic [1:0] sel_now; // Clock select seen by the divider
   logic in_cal; // Calibration phase
   logic in_idle; // Waiting for a request
   logic in_sample; // Sample switch closed
   logic in_conv; // Conversion steps running
   logic in_load; // Result load cycles
   logic load_last; // Final CPU cycle of the load
   logic cal_last; // Final period of calibration

   // State decode, one wire per phase
   assign in_cal = (state_r == ST_CAL);
   assign in_idle = (state_r == ST_IDLE);
   assign in_sample = (state_r == ST_SAMPLE);
   assign in_conv = (state_r == ST_CONV);
   assign in_load = (state_r == ST_LOAD);

   // Divider follows the new select in the start cycle itself,
   // so the first basic period of a conversion already has the
   // programmed length; afterwards the latched copy is used and
   // software may rewrite the control word freely
   assign sel_now = take_start ? CTRL.conv_clock_select : ctrl_r.conv_clock_select;

   // Basic clock divider; realigned at each start
   ats_bc_divider u_div (
      .SYS_CLK(SYS_CLK), // CPU clock
      .RESET_N(RESET_N), // Async reset
      .restart(restart), // Phase zero at start
      .sel(sel_now), // Divisor code
      .tick(tick) // Basic period end
   );

   // Start only when idle; requests while busy are dropped
   assign take_start = in_idle && START;
   // Realigning the divider makes every conversion equally long
   assign restart = take_start;

   // Sample length decode
   assign sample_len = (ctrl_r.sample_time_select == 2'h0) ? SAMPLE_BC_0 :
                       (ctrl_r.sample_time_select == 2'h1) ? SAMPLE_BC_1 :
                       (ctrl_r.sample_time_select == 2'h2) ? SAMPLE_BC_2 : SAMPLE_BC_3;

   // Length of the running phase in basic periods; idle and load
   // fall through to the step count, where the counter is unused
   assign phase_end = in_cal ? 12'(CAL_PERIODS) :
                      in_sample ? {5'h00, sample_len} :
                      {5'h00, CONV_STEP_BC};
   // Phase ends on the tick that closes its last basic period
   assign phase_last = tick && (per_cnt_r == phase_end - 12'h001);
   // Calibration ends on its last period
   assign cal_last = in_cal && phase_last;
   // Last of the trailing CPU cycles that load the result
   assign load_last = in_load && (load_cnt_r == LOAD_CPU_CYCLES - 2'h1);

   // Saturation of out-of-range inputs; under-range is tested
   // first so a front end flagging both still gives a defined code
   assign sat_code = held_r.below_gnd ? RES_ZERO :
                     held_r.above_ref ? RES_FULL : held_r.code;

   // Next state
   always_comb begin
      // Stay put unless a phase ends
      state_nxt = state_r;
      unique case (state_r)
         // Calibration after reset, at the reset divisor
         ST_CAL: begin
            if (phase_last) begin
               // Converter ready for requests
               state_nxt = ST_IDLE;
            end
         end
         // Wait for a request
         ST_IDLE: begin
            if (take_start) begin
               // Close the sample switch
               state_nxt = ST_SAMPLE;
            end
         end
         // Input tracked for the programmed sample time
         ST_SAMPLE: begin
            if (phase_last) begin
               // Open the switch, keep the last value
               state_nxt = ST_CONV;
            end
         end
         // Forty approximation steps
         ST_CONV: begin
            if (phase_last) begin
               // Steps done, load the result
               state_nxt = ST_LOAD;
            end
         end
         // Two CPU cycles to load the result register; they run
         // on the CPU clock, so they do not scale with the divisor
         ST_LOAD: begin
            if (load_last) begin
               // Result stands, ready again
               state_nxt = ST_IDLE;
            end
         end
         // Unused codes recover through calibration
         default: begin
            state_nxt = ST_CAL;
         end
      endcase
   end

   // Period counter restarts at each phase and start; it only
   // moves on basic clock ticks so the calibration, sample and step
   // phases count whole basic periods whatever the divisor
   assign per_cnt_nxt = (take_start || phase_last) ? 12'h000 :
                        tick ? per_cnt_r + 12'h001 : per_cnt_r;

   // State and counters
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         // Calibration always follows reset
         state_r <= ST_CAL;
         per_cnt_r <= 12'h000;
         load_cnt_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         per_cnt_r <= per_cnt_nxt;
         // Load cycles counted on the CPU clock, not the basic one
         load_cnt_r <= in_load ? load_cnt_r + 2'h1 : 2'h0;
      end
   end

   // Settings latched at start for the whole conversion;
   // a rewrite mid-conversion takes effect at the next start
   // and cannot stretch or cut the running one
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_r <= '0;
      end else if (take_start) begin
         ctrl_r <= CTRL;
      end
   end

   // Track input while sampling, freeze after; the value of the
   // last sample cycle is the one that converts, and anything the
   // pin does later is ignored
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         held_r <= '0;
      end else if (in_sample) begin
         held_r <= AIN;
      end
   end

   // Result register and completion flags
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         result_r <= RES_ZERO;
         done_r <= 1'b0;
         cal_done_r <= 1'b0;
      end else begin
         // One-cycle pulse alongside the new result
         done_r <= load_last;
         // Result register loaded in the last load cycle
         if (load_last) begin
            result_r <= sat_code;
         end
         // Stays set until the next reset
         if (cal_last) begin
            cal_done_r <= 1'b1;
         end
      end
   end

   // BUSY, SAMPLING and HOLD decoded straight from the state register,
   // so they move in the cycle the state does
   assign BUSY = !in_idle; // Calibrating or converting
   assign CAL_DONE = cal_done_r;
   assign SAMPLING = in_sample; // Switch closed only here
   // Hold covers the steps and the load cycles
   assign HOLD = in_conv || in_load;
   assign DONE = done_r;
   assign RESULT = result_r;
endmodule : ats_sequencer

//--- test/ats_sequencer_properties.sv
`timescale 1ns/1ps
module ats_chk
   import ats_pkg::*;
#(
   parameter int CAL_PERIODS = 4 // Calibration periods
)(
   input wire logic SYS_CLK, // CPU clock
   input wire logic RESET_N, // Async reset
   input wire ats_ctrl_s CTRL, // Select fields
   input wire logic START, // Request
   input wire logic BUSY, // Busy
   input wire logic CAL_DONE, // Calibrated
   input wire logic SAMPLING, // Sample phase
   input wire logic HOLD, // Hold phase
   input wire logic DONE, // Result pulse
   input wire logic [RES_W-1:0] RESULT // Result
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   ats_ctrl_s ctl_r; // Select taken at start
   logic [11:0] scnt_r, hcnt_r, ccnt_r; // Phase lengths
   logic [11:0] div_w, smp_w; // Divisor, sample length
   assign div_w = (ctl_r.conv_clock_select == CLK_SEL_DIV4) ? 12'(DIV_BY_4) :
                  (ctl_r.conv_clock_select == CLK_SEL_DIV2) ? 12'(DIV_BY_2) :
                  (ctl_r.conv_clock_select == CLK_SEL_DIV16) ? 12'(DIV_BY_16) : 12'(DIV_BY_8);
   assign smp_w = (12'h8 << ctl_r.sample_time_select) * div_w;
   // Latch select and count phase cycles
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctl_r <= '0;
         scnt_r <= '0;
         hcnt_r <= '0;
         ccnt_r <= '0;
      end else begin
         ctl_r <= (START && !BUSY) ? CTRL : ctl_r;
         scnt_r <= SAMPLING ? scnt_r + 12'h1 : 12'h0;
         hcnt_r <= HOLD ? hcnt_r + 12'h1 : 12'h0;
         ccnt_r <= CAL_DONE ? 12'h0 : ccnt_r + 12'h1;
      end
   end
   samp_len_a: assert property ($fell(SAMPLING) |-> scnt_r == smp_w) else $error("sample length");
   hold_len_a: assert property ($fell(HOLD) |-> hcnt_r == 12'(CONV_STEP_BC) * div_w + 12'(LOAD_CPU_CYCLES))
      else $error("hold length");
   samp_hold_a: assert property ($fell(SAMPLING) |-> HOLD) else $error("no hold after sample");
   start_samp_a: assert property (START && !BUSY |=> SAMPLING && BUSY) else $error("start not taken");
   done_pulse_a: assert property (DONE |=> !DONE) else $error("done too long");
   res_stable_a: assert property (!DONE |-> $stable(RESULT)) else $error("result moved");
   cal_len_a: assert property (!CAL_DONE |-> BUSY && ccnt_r <= CAL_PERIODS * 4 + 2) else $error("calibration");
   cover property ($fell(SAMPLING) && ctl_r.conv_clock_select == CLK_SEL_DIV16);
   cover property (DONE && RESULT == RES_FULL);
   cover property ($rose(CAL_DONE));
endmodule : ats_chk
bind ats_sequencer ats_chk #(.CAL_PERIODS(CAL_PERIODS)) u_chk (.*);

//--- test/ats_ain_model.sv
`timescale 1ns/1ps
module ats_ain_model
   import ats_pkg::*;
(
   input wire logic clk, // CPU clock
   input wire logic rst_n, // Reset
   input wire logic sampling, // Switch closed
   input wire ats_ain_s level, // Level while sampled
   output ats_ain_s ain // Front end report
);
   // Steady while sampled, toggling otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ain <= '0;
      else if (sampling) ain <= level;
      else ain <= ~ain;
   end
endmodule : ats_ain_model

//--- test/tb_ats_sequencer.sv
`timescale 1ns/1ps
module tb_ats_sequencer;
   import ats_pkg::*;
   localparam int CALP = 4; // Short calibration
   logic sys_clk = 1'b0, reset_n = 1'b0, start = 1'b0; // Clock, reset, request
   ats_ctrl_s ctrl = '0; // Select fields
   ats_ain_s level = '0, ain; // Presented and seen input
   logic busy, cal_done, sampling, hold, done; // Status
   logic [RES_W-1:0] result; // Result
   int fail_count = 0, check_count = 0; // Tallies
   always #5 sys_clk = ~sys_clk;
   ats_ain_model pm (.clk(sys_clk), .rst_n(reset_n), .sampling(sampling), .level(level), .ain(ain));
   ats_sequencer #(.CAL_PERIODS(CALP)) DUT (.SYS_CLK(sys_clk), .RESET_N(reset_n), .CTRL(ctrl),
      .START(start), .AIN(ain), .BUSY(busy), .CAL_DONE(cal_done), .SAMPLING(sampling),
      .HOLD(hold), .DONE(done), .RESULT(result));
   // Compare one value
   task automatic chk(string n, logic [9:0] e, logic [9:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // Compare one cycle count
   task automatic chk_cyc(string n, int e, int g);
      check_count++;
      if (g != e) begin
         fail_count++;
         $display("ERROR %s exp %0d got %0d", n, e, g);
      end
   endtask : chk_cyc
   task automatic end_sim;
      if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   // Saturation, below ground first
   function automatic logic [9:0] exp_res(ats_ain_s a);
      return a.below_gnd ? RES_ZERO : (a.above_ref ? RES_FULL : a.code);
   endfunction : exp_res
   // Conversion length in CPU cycles from the select fields
   function automatic int exp_cyc(logic [3:0] c);
      int d;
      int s;
      d = (c[3:2] == CLK_SEL_DIV4) ? DIV_BY_4 : (c[3:2] == CLK_SEL_DIV2) ? DIV_BY_2 :
          (c[3:2] == CLK_SEL_DIV16) ? DIV_BY_16 : DIV_BY_8;
      s = (c[1:0] == 2'h0) ? SAMPLE_BC_0 : (c[1:0] == 2'h1) ? SAMPLE_BC_1 :
          (c[1:0] == 2'h2) ? SAMPLE_BC_2 : SAMPLE_BC_3;
      return (s + CONV_STEP_BC) * d + LOAD_CPU_CYCLES;
   endfunction : exp_cyc
   // One conversion, start held into busy
   task automatic conv(input logic [3:0] c, input ats_ain_s a);
      int n;
      @(posedge sys_clk);
      ctrl <= c;
      level <= a;
      start <= 1'b1;
      repeat (3) @(posedge sys_clk);
      start <= 1'b0;
      for (n = 0; n < 2000 && done !== 1'b1; n++) @(negedge sys_clk);
      if (n == 2000) begin
         fail_count++;
         end_sim();
      end else begin
         chk("result", exp_res(a), result);
         chk_cyc("conv_time", exp_cyc(c), n + 1);
      end
   endtask : conv
   initial begin
      ats_ain_s a;
      int n;
      n = $urandom(32'h639D85A5);
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (n = 0; n < 100 && cal_done !== 1'b1; n++) @(negedge sys_clk);
      chk("cal_time", 10'h1, 10'(n <= CALP * 4 + 2));
      // Every select pair, plus saturation cases
      for (int i = 0; i < 16; i++) begin
         a = ats_ain_s'(12'($urandom));
         a.below_gnd = (i % 4 == 1) || (i % 4 == 3);
         a.above_ref = (i % 4 >= 2);
         conv(4'(i), a);
      end
      // Random runs at the divisor that keeps the basic clock in range at this CPU rate
      for (int i = 0; i < 6; i++) begin
         a = ats_ain_s'(12'($urandom));
         conv({CLK_SEL_DIV16, 2'($urandom)}, a);
      end
      end_sim();
   end
endmodule : tb_ats_sequencer
